// ### hdl/ep_gate.sv
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"

module ep_gate
  import usb_ep_pkg::*;
(
  // Endpoint control bits
  input wire logic [7:0] ctrl_i,
  // Token to judge
  input wire tok_kind_t kind_i,
  // Decision
  output logic accept_o,
  output logic handshake_o
);

  logic rx_en;
  logic tx_en;
  logic setup_dis;

  assign rx_en = ctrl_i[`EPB_RX_EN];
  assign tx_en = ctrl_i[`EPB_TX_EN];
  // Only honoured when both directions are on
  assign setup_dis = ctrl_i[`EPB_SETUP_DIS] & rx_en & tx_en; // RULE_05

  always_comb
  begin
    unique case (kind_i)
      tok_out:
      begin
        accept_o = rx_en; // RULE_06
      end
      tok_in:
      begin
        accept_o = tx_en; // RULE_07
      end
      tok_setup:
      begin
        accept_o = rx_en & ~setup_dis; // RULE_04
      end
      default:
      begin
        accept_o = 1'b0;
      end
    endcase
  end

  assign handshake_o = accept_o & ctrl_i[`EPB_HSHK_EN]; // RULE_09

endmodule

// ### hdl/usb_endpoint_control.sv
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"

// Overview of operation
// RULE_01: Sixteen identical registers, one per endpoint.
// RULE_02: Endpoint zero low-speed bit: direct, else PRE.
// RULE_03: Endpoint zero retry-disable stops hardware NAK retries.
// RULE_04: Setup-disable rejects SETUP when both directions on.
// RULE_05: Setup-disable ignored unless transmit and receive on.
// RULE_06: Receive accepted only while receive enable set.
// RULE_07: Transmit performed only while transmit enable set.
// RULE_08: Stall bit reads one when endpoint stalled.
// RULE_09: Handshakes issued only while handshake enable set.
// RULE_10: Bits 31-8 and 5 read zero.
// RULE_11: Stall bit set by hardware, cleared by software.
module usb_endpoint_control
  import usb_ep_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // USB engine token request
  input wire logic host_mode_i,
  input wire logic tok_valid_i,
  input wire logic [3:0] tok_ep_i,
  input wire tok_kind_t tok_kind_i,
  input wire logic [15:0] stall_set_i,
  // USB engine token answer
  output logic tok_done_o,
  output logic tok_accept_o,
  output logic tok_handshake_o,
  output logic tok_stalled_o,
  // Host-mode link options
  output logic use_pre_prefix_o,
  output logic nak_retry_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  bus_state_t bus_q;
  logic req;
  logic done;
  logic wr_done;
  logic ep_hit;
  logic stat_hit;
  logic mask_hit;
  logic [3:0] ep_idx;
  logic [31:0] be_mask;
  logic [7:0] ep_ctrl_w [16];
  logic [15:0] gate_acc;
  logic [15:0] gate_hs;
  logic [15:0] stall_flags;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic [`IRQ_W-1:0] irq_set;
  logic [`IRQ_W-1:0] irq_clr;
  logic [31:0] rdata_d;
  logic refused;

  assign req = avs_read_i | avs_write_i;
  // Access completes in the cycle waitrequest is low
  assign done = req & (bus_q == bus_ack);
  assign wr_done = done & avs_write_i;
  assign ep_idx = avs_address_i[5:2];
  assign ep_hit = (avs_address_i[7:6] == 2'h0) &
                  (avs_address_i[1:0] == 2'h0);
  assign stat_hit = avs_address_i == `IRQ_STAT_ADDR;
  assign mask_hit = avs_address_i == `IRQ_MASK_ADDR;

  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_be
      assign be_mask[8*b+7:8*b] = {8{avs_byteenable_i[b]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the answer

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      bus_q <= bus_idle;
      avs_waitrequest_o <= 1'b1;
    end
    else
    begin
      unique case (bus_q)
        bus_idle:
        begin
          if (req)
          begin
            bus_q <= bus_ack;
            avs_waitrequest_o <= 1'b0;
          end
        end
        bus_ack:
        begin
          bus_q <= bus_idle;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (ep_hit)
    begin
      // Upper bits and bit 5 are never stored, so read zero
      rdata_d = {24'h00_0000, ep_ctrl_w[ep_idx]}; // RULE_10
    end
    else if (stat_hit)
    begin
      rdata_d[`IRQ_W-1:0] = irq_stat_q;
    end
    else if (mask_hit)
    begin
      rdata_d[`IRQ_W-1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= `RESP_OKAY;
    end
    else if (req && bus_q == bus_idle)
    begin
      avs_readdata_o <= avs_read_i ? rdata_d : 32'h0000_0000;
      avs_response_o <= (ep_hit | stat_hit | mask_hit) ?
                        `RESP_OKAY : `RESP_DECERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Endpoint registers and token gates

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_ep
      logic [7:0] ctrl_q;
      logic wr_me;

      assign wr_me = wr_done & ep_hit & avs_byteenable_i[0] &
                     (ep_idx == 4'(g));

      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          ctrl_q <= `EP_CTRL_RST;
        end
        else
        begin
          if (wr_me)
          begin
            ctrl_q <= avs_writedata_i[7:0] & `EP_CTRL_WMASK; // RULE_01
          end
          // A stall in the same cycle as a software clear wins
          if (stall_set_i[g])
          begin
            ctrl_q[`EPB_STALLED] <= 1'b1; // RULE_11
          end
        end
      end

      assign ep_ctrl_w[g] = ctrl_q; // RULE_08
      assign stall_flags[g] = ctrl_q[`EPB_STALLED];

      ep_gate u_gate (
        .ctrl_i(ctrl_q),
        .kind_i(tok_kind_i),
        .accept_o(gate_acc[g]),
        .handshake_o(gate_hs[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Token answer, one cycle after the request

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      tok_done_o <= 1'b0;
      tok_accept_o <= 1'b0;
      tok_handshake_o <= 1'b0;
      tok_stalled_o <= 1'b0;
    end
    else
    begin
      tok_done_o <= tok_valid_i;
      tok_accept_o <= tok_valid_i & gate_acc[tok_ep_i]; // RULE_06 RULE_07
      tok_handshake_o <= tok_valid_i & gate_hs[tok_ep_i]; // RULE_09
      tok_stalled_o <= tok_valid_i & ep_ctrl_w[tok_ep_i][`EPB_STALLED];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host-mode options, taken from endpoint zero only

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      use_pre_prefix_o <= 1'b0;
      nak_retry_o <= 1'b0;
    end
    else
    begin
      use_pre_prefix_o <= host_mode_i &
                          ~ep_ctrl_w[0][`EPB_LOW_SPEED]; // RULE_02
      nak_retry_o <= host_mode_i &
                     ~ep_ctrl_w[0][`EPB_NAK_RETRY_DIS]; // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins

  assign refused = tok_valid_i & ~gate_acc[tok_ep_i];
  assign irq_set = {refused, stall_set_i};
  assign irq_clr = (wr_done & stat_hit) ?
                   (avs_writedata_i[`IRQ_W-1:0] &
                    be_mask[`IRQ_W-1:0]) : `IRQ_RST;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      irq_stat_q <= `IRQ_RST;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      irq_mask_q <= `IRQ_RST;
    end
    else if (wr_done && mask_hit)
    begin
      irq_mask_q <= (irq_mask_q & ~be_mask[`IRQ_W-1:0]) |
                    (avs_writedata_i[`IRQ_W-1:0] & be_mask[`IRQ_W-1:0]);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |((irq_stat_q & ~irq_clr | irq_set) & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  a_ep_write_lands: assert property ( // RULE_01
    (wr_done && ep_hit && avs_byteenable_i[0] && !(|stall_set_i)) |=>
    ((ep_ctrl_w[$past(ep_idx)] ^ $past(avs_writedata_i[7:0])) &
     `EP_CTRL_WMASK) == 8'h00)
    else $error("endpoint register write lost");

  a_pre_prefix: assert property ( // RULE_02
    ##1 use_pre_prefix_o ==
    ($past(host_mode_i) && !$past(ep_ctrl_w[0][`EPB_LOW_SPEED])))
    else $error("PRE prefix choice wrong");

  a_nak_retry: assert property ( // RULE_03
    ##1 nak_retry_o ==
    ($past(host_mode_i) && !$past(ep_ctrl_w[0][`EPB_NAK_RETRY_DIS])))
    else $error("NAK retry choice wrong");

  a_setup_blocked: assert property ( // RULE_04
    (tok_valid_i && tok_kind_i == tok_setup &&
     ep_ctrl_w[tok_ep_i][`EPB_SETUP_DIS] &&
     ep_ctrl_w[tok_ep_i][`EPB_RX_EN] &&
     ep_ctrl_w[tok_ep_i][`EPB_TX_EN]) |=> tok_done_o && !tok_accept_o)
    else $error("SETUP accepted while disabled");

  a_setup_dis_ignored: assert property ( // RULE_05
    (tok_valid_i && tok_kind_i == tok_setup &&
     ep_ctrl_w[tok_ep_i][`EPB_RX_EN] &&
     !ep_ctrl_w[tok_ep_i][`EPB_TX_EN]) |=> tok_accept_o)
    else $error("SETUP refused on receive-only endpoint");

  a_rx_gate: assert property ( // RULE_06
    (tok_valid_i && tok_kind_i == tok_out) |=>
    tok_accept_o == $past(ep_ctrl_w[tok_ep_i][`EPB_RX_EN]))
    else $error("receive gate wrong");

  a_tx_gate: assert property ( // RULE_07
    (tok_valid_i && tok_kind_i == tok_in) |=>
    tok_accept_o == $past(ep_ctrl_w[tok_ep_i][`EPB_TX_EN]))
    else $error("transmit gate wrong");

  a_stall_shows: assert property ( // RULE_08
    (|stall_set_i) |=>
    (stall_flags & $past(stall_set_i)) == $past(stall_set_i))
    else $error("stall not reported");

  a_stall_readback: assert property ( // RULE_08
    (avs_read_i && ep_hit && bus_q == bus_idle) |=>
    avs_readdata_o[`EPB_STALLED] ==
    $past(ep_ctrl_w[ep_idx][`EPB_STALLED]))
    else $error("stall bit not read back");

  a_hshk_gate: assert property ( // RULE_09
    tok_done_o |-> tok_handshake_o ==
    (tok_accept_o && $past(ep_ctrl_w[tok_ep_i][`EPB_HSHK_EN])))
    else $error("handshake gate wrong");

  a_reserved_zero: assert property ( // RULE_10
    (avs_read_i && ep_hit && bus_q == bus_idle) |=>
    !avs_waitrequest_o && avs_readdata_o[31:8] == 24'h00_0000 &&
    !avs_readdata_o[5])
    else $error("reserved bits read nonzero");

  a_stall_sticky: assert property ( // RULE_11
    (ep_ctrl_w[0][`EPB_STALLED] &&
     !(wr_done && ep_hit && ep_idx == 4'h0)) |=>
    ep_ctrl_w[0][`EPB_STALLED])
    else $error("stall bit dropped without write");

  a_irq_level: assert property (
    ##1 irq_o == |(irq_stat_q & $past(irq_mask_q)))
    else $error("interrupt level wrong");

  c_setup_refused: cover property (
    tok_valid_i && tok_kind_i == tok_setup ##1 !tok_accept_o);
  c_stall_irq: cover property (stall_set_i[0] ##[1:4] irq_o);
  c_bus_read: cover property (avs_read_i && !avs_waitrequest_o);

endmodule

// ### hdl/usb_ep_cfg.svh
`ifndef USB_EP_CFG_SVH
`define USB_EP_CFG_SVH

// Byte addresses on the register bus
`define EP_CTRL_BASE 8'h00
`define EP_CTRL_LAST 8'h3C
`define IRQ_STAT_ADDR 8'h40
`define IRQ_MASK_ADDR 8'h44

// Endpoint control field positions
`define EPB_LOW_SPEED 7
`define EPB_NAK_RETRY_DIS 6
`define EPB_SETUP_DIS 4
`define EPB_RX_EN 3
`define EPB_TX_EN 2
`define EPB_STALLED 1
`define EPB_HSHK_EN 0

// Reset values and implemented bits
`define EP_CTRL_RST 8'h00
`define EP_CTRL_WMASK 8'hDF
`define IRQ_RST 17'h00000

// Interrupt status layout: 15:0 stall per endpoint, 16 refused token
`define IRQ_W 17
`define IRQ_REFUSED 16

// Avalon-MM response codes
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ### hdl/usb_ep_pkg.sv
package usb_ep_pkg;

  typedef enum logic [1:0] {
    tok_out,
    tok_in,
    tok_setup
  } tok_kind_t;

  typedef enum logic {
    bus_idle,
    bus_ack
  } bus_state_t;

endpackage

// ### verif/usb_endpoint_control_tb.sv
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"
module usb_endpoint_control_tb
  import usb_ep_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic host = 1'b0;
  logic [31:0] rdo;
  logic [1:0] resp;
  logic wait_req, tok_valid, done, acc_o, hs_o, stl_o, pre_o, retry_o, irq;
  logic [3:0] tok_ep;
  tok_kind_t tok_kind;
  logic [15:0] stall_set;
  logic [31:0] ep_m [16];
  logic [31:0] c, rd;
  logic [1:0] rsp;
  logic a;
  int s;
  int cycles = 0;
  int n_errors = 0;
  int checks_done = 0;

  always #2.5 clock_i = ~clock_i;

  usb_endpoint_control i_usb_endpoint_control (
    .clock_i(clock_i), .reset_i(reset_i),
    .avs_address_i(adr), .avs_read_i(rd_en), .avs_write_i(wr_en),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdo), .avs_response_o(resp),
    .avs_waitrequest_o(wait_req), .host_mode_i(host),
    .tok_valid_i(tok_valid), .tok_ep_i(tok_ep), .tok_kind_i(tok_kind),
    .stall_set_i(stall_set), .tok_done_o(done), .tok_accept_o(acc_o),
    .tok_handshake_o(hs_o), .tok_stalled_o(stl_o),
    .use_pre_prefix_o(pre_o), .nak_retry_o(retry_o), .irq_o(irq)
  );

  usb_engine_model i_usb_engine_model (
    .clock_i(clock_i), .tok_valid_o(tok_valid), .tok_ep_o(tok_ep),
    .tok_kind_o(tok_kind), .stall_set_o(stall_set)
  );
  ////////////////////////////////////////
  task check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task complete_run();
    $display("Checks made %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Request held until waitrequest is seen low; one idle cycle after
  task bus_wr(input logic [7:0] ad, input logic [31:0] d);
    adr <= ad;
    wdata <= d;
    wr_en <= 1'b1;
    do @(posedge clock_i); while (wait_req !== 1'b0);
    rsp = resp;
    wr_en <= 1'b0;
    @(posedge clock_i);
  endtask

  task bus_rd(input logic [7:0] ad, output logic [31:0] d);
    adr <= ad;
    rd_en <= 1'b1;
    do @(posedge clock_i); while (wait_req !== 1'b0);
    d = rdo;
    rsp = resp;
    rd_en <= 1'b0;
    @(posedge clock_i);
  endtask

  // A hang ends the run as a failure
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(62));
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    for (int n = 0; n < 18; n++)
    begin
      bus_rd(8'(4 * n), rd);
      check({rsp, rd}, {`RESP_OKAY, 32'h0});
    end
    // Random settings, then every token kind on every endpoint
    repeat (2)
    begin
      for (int n = 0; n < 16; n++)
      begin
        ep_m[n] = $urandom;
        bus_wr(8'(4 * n), ep_m[n]);
        ep_m[n] &= 32'hDF;
        bus_rd(8'(4 * n), rd);
        check(rd, ep_m[n]);
      end
      for (int n = 0; n < 16; n++)
        for (int k = 0; k < 4; k++)
        begin
          i_usb_engine_model.token(n[3:0], tok_kind_t'(k[1:0]));
          @(posedge clock_i);
          c = ep_m[n];
          case (k)
            0: a = c[3];
            1: a = c[2];
            2: a = c[3] & !(c[2] & c[4]);
            default: a = 1'b0;
          endcase
          check({done, acc_o, hs_o}, {1'b1, a, a & c[0]});
          check(stl_o, c[1]);
        end
    end
    // Illegal token kinds were refused, no stall event yet
    bus_rd(`IRQ_STAT_ADDR, rd);
    check(rd, 32'h0001_0000);
    bus_wr(8'h48, 32'hFFFFFFFF);
    bus_rd(8'h48, rd);
    check({rsp, rd}, {`RESP_DECERR, 32'h0});
    for (int i = 0; i < 8; i++)
    begin
      c = 32'(i[1:0]) << 6;
      host <= i[2];
      bus_wr(8'h00, c);
      repeat (2) @(posedge clock_i);
      check({pre_o, retry_o}, {i[2] & !c[7], i[2] & !c[6]});
    end
    bus_wr(`IRQ_STAT_ADDR, 32'h1FFFF);
    bus_rd(`IRQ_STAT_ADDR, rd);
    check(rd, 32'h0);
    s = $urandom_range(15);
    bus_wr(8'(4 * s), 32'h0D);
    i_usb_engine_model.stall(s[3:0]);
    bus_rd(8'(4 * s), rd);
    check(rd, 32'h0F);
    bus_rd(`IRQ_STAT_ADDR, rd);
    check({irq, rd}, {1'b0, 32'h1 << s});
    bus_wr(`IRQ_MASK_ADDR, 32'h1 << s);
    repeat (2) @(posedge clock_i);
    check(irq, 1'b1);
    bus_wr(`IRQ_STAT_ADDR, 32'h1 << s);
    repeat (2) @(posedge clock_i);
    check(irq, 1'b0);
    i_usb_engine_model.token(s[3:0], tok_in);
    @(posedge clock_i);
    check({acc_o, stl_o}, 2'b11);
    bus_wr(8'(4 * s), 32'h0D);
    bus_rd(8'(4 * s), rd);
    check(rd, 32'h0D);
    complete_run();
  end
endmodule

// ### verif/usb_engine_model.sv
`timescale 1ns/1ps
module usb_engine_model
  import usb_ep_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Token request and stall events
  output logic tok_valid_o,
  output logic [3:0] tok_ep_o,
  output tok_kind_t tok_kind_o,
  output logic [15:0] stall_set_o
);
  initial
  begin
    tok_valid_o = 1'b0;
    tok_ep_o = 4'h0;
    tok_kind_o = tok_out;
    stall_set_o = 16'h0000;
  end
  ////////////////////////////////////////
  // Lines flip to the inverse once a token is over, so a late
  // sample sees a wrong value rather than a lucky one
  task automatic token(input logic [3:0] e, input tok_kind_t k);
    tok_ep_o <= e;
    tok_kind_o <= k;
    tok_valid_o <= 1'b1;
    @(posedge clock_i);
    tok_valid_o <= 1'b0;
    tok_ep_o <= ~e;
    tok_kind_o <= tok_kind_t'(~k);
  endtask
  // One-cycle stall event
  task automatic stall(input logic [3:0] e);
    stall_set_o <= 16'h0001 << e;
    @(posedge clock_i);
    stall_set_o <= 16'h0000;
  endtask
endmodule
